// ===== core/gdo_consts.vh
/*
  constants for the gpio output-value register block: register offset,
  field positions, reset value and pin count.
  assumes inclusion by bare name from the design files under core/.
*/
`ifndef GDO_CONSTS_VH
`define GDO_CONSTS_VH

// ==========================================================
// register map
`define GDO_OUT_VALUE_OFFS   12'h00c
`define GDO_ADDR_W           12
`define GDO_NUM_PINS         9

// ==========================================================
// field positions
`define GDO_LANE0_VAL_LSB    0
`define GDO_LANE0_MSK_LSB    4
`define GDO_LANE1_VAL_LSB    8
`define GDO_LANE1_MSK_LSB    12
`define GDO_PIN8_VAL_BIT     16
`define GDO_PIN8_MSK_BIT     20
`define GDO_PINS_PER_LANE    4

// ==========================================================
// reset values
`define GDO_OUT_VALUE_RST    9'h000
`define GDO_RDATA_RST        32'h0000_0000

`endif

// ===== core/gdo_out_value.v
/*
  gpio output-value register with per-pin write mask, on an apb slave,
  and the pin drive gating from external mux and direction settings.
  assumes: one clock mclk, synchronous active-low rst_n, apb master on the
  same clock; pin-mux and direction settings come from logic on mclk.
*/
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "gdo_consts.vh"

module gdo_out_value #(
  parameter NPINS = `GDO_NUM_PINS
) (
  input  wire                    mclk,
  input  wire                    rst_n,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`GDO_ADDR_W-1:0]  paddr,
  input  wire [31:0]             pwdata,
  input  wire [3:0]              pstrb,
  output wire                    pready,
  output reg  [31:0]             prdata,
  output wire                    pslverr,
  input  wire [NPINS-1:0]        pin_gpio_sel,
  input  wire [NPINS-1:0]        pin_direction_bit,
  input  wire [NPINS-1:0]        pin_in,
  output wire [NPINS-1:0]        pin_out,
  output wire [NPINS-1:0]        pin_oe_n
);

  // ==========================================================
  // field location helpers
  // value bit position of pin p in the register word
  function integer val_pos;
    input integer p;
    begin
      if (p < `GDO_PINS_PER_LANE)
        val_pos = `GDO_LANE0_VAL_LSB + p;
      else if (p < 2 * `GDO_PINS_PER_LANE)
        val_pos = `GDO_LANE1_VAL_LSB + p - `GDO_PINS_PER_LANE;
      else
        val_pos = `GDO_PIN8_VAL_BIT;
    end
  endfunction

  // mask bit position; pin 6 takes bit 14 so pin 7 keeps bit 15
  function integer msk_pos;
    input integer p;
    begin
      if (p < `GDO_PINS_PER_LANE)
        msk_pos = `GDO_LANE0_MSK_LSB + p;
      else if (p < 2 * `GDO_PINS_PER_LANE)
        msk_pos = `GDO_LANE1_MSK_LSB + p - `GDO_PINS_PER_LANE;
      else
        msk_pos = `GDO_PIN8_MSK_BIT;
    end
  endfunction

  // ==========================================================
  // apb decode
  wire       hit      = (paddr == `GDO_OUT_VALUE_OFFS);
  wire       acc      = psel & penable;
  wire       wr_en    = acc & pwrite & hit;
  reg  [NPINS-1:0] out_q;
  reg  [NPINS-1:0] out_d;
  wire [31:0]      rd_word;

  // zero-wait slave; unmapped addresses read zero, writes dropped
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pin
      localparam integer VP = val_pos(g);
      localparam integer MP = msk_pos(g);
      // the byte strobe of each field's lane qualifies it too
      wire lane_ok = pstrb[VP / 8] & pstrb[MP / 8];
      always @* begin
        out_d[g] = out_q[g];
        if (wr_en && lane_ok && pwdata[MP])
          out_d[g] = pwdata[VP];
      end
      // masks not stored at all, so they read zero
      assign rd_word[VP] = out_q[g];
      // pin drive: gpio mode and direction zero (output)
      assign pin_out[g]  = out_q[g];
      assign pin_oe_n[g] = ~(pin_gpio_sel[g] & ~pin_direction_bit[g]);
    end
    // every non-value bit, masks and reserved, reads zero
    for (g = 0; g < 32; g = g + 1) begin : g_zero
      if (g != val_pos(0) && g != val_pos(1) && g != val_pos(2) && g != val_pos(3) &&
          g != val_pos(4) && g != val_pos(5) && g != val_pos(6) && g != val_pos(7) &&
          g != val_pos(8)) begin : g_z
        assign rd_word[g] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      out_q  <= `GDO_OUT_VALUE_RST;
      prdata <= `GDO_RDATA_RST;
    end else begin
      out_q <= out_d;
      // read data registered in setup cycle, valid in access phase
      if (psel && !penable && !pwrite && hit)
        prdata <= rd_word;
      else if (psel && !penable)
        prdata <= `GDO_RDATA_RST;
    end
  end

endmodule // gdo_out_value

// ===== dv/gdo_out_value_chk.sv
/* port checker for gdo_out_value
   assumes bind onto every instance, all on mclk */
`timescale 1ns/1ps
module gdo_chk (input wire mclk, rst_n, psel, penable, pwrite, input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata, input wire [3:0] pstrb,
  input wire [8:0] pin_gpio_sel, pin_direction_bit, pin_out, pin_oe_n);
  wire wr = psel && penable && pwrite && paddr == 12'h00c;
  wire rd = psel && penable && !pwrite;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_oe; pin_oe_n == ~(pin_gpio_sel & ~pin_direction_bit); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_msk; rd |-> (prdata & 32'hfffe_f0f0) == 32'h0; endproperty
  a_msk: assert property (p_msk) else $error("mask bits read set");
  property p_rd; rd && paddr == 12'h00c |-> {prdata[16], prdata[11:8], prdata[3:0]} == pin_out; endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");
  property p_0; wr && pstrb[0] && pwdata[4] |=> pin_out[0] == $past(pwdata[0]); endproperty
  a_0: assert property (p_0) else $error("pin0 write lost");
  property p_4; wr && pstrb[1] && pwdata[12] |=> pin_out[4] == $past(pwdata[8]); endproperty
  a_4: assert property (p_4) else $error("pin4 write lost");
  property p_6; wr && pstrb[1] && pwdata[14] |=> pin_out[6] == $past(pwdata[10]); endproperty
  a_6: assert property (p_6) else $error("pin6 write lost");
  property p_8; wr && pstrb[2] && pwdata[20] |=> pin_out[8] == $past(pwdata[16]); endproperty
  a_8: assert property (p_8) else $error("pin8 write lost");
  property p_hold; !(wr && (pwdata & 32'h0011_f0f0) != 0) |=> $stable(pin_out); endproperty
  a_hold: assert property (p_hold) else $error("unmasked change");
endmodule // gdo_chk
bind gdo_out_value gdo_chk u_chk (.*);

// ===== dv/testbench.sv
/* random masked writes and readback over apb
   assumes the checker is bound from its own file */
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0, a;
  logic [31:0] pwdata = 0, prdata, r, d;
  logic [3:0]  pstrb = 0, s;
  logic [8:0]  sel = 0, dir = 0, pin_out, pin_oe_n, e = 0;
  int error_cnt = 0, n_checks = 0, i;
  always #4 mclk = ~mclk;
  gdo_out_value dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .pin_gpio_sel(sel), .pin_direction_bit(dir), .pin_in(9'h0), .pin_out, .pin_oe_n);
  function automatic [8:0] f_upd(input [8:0] o, input [31:0] w, input [3:0] b);
    int k, p;
    f_upd = o;
    for (k = 0; k < 9; k++) begin
      p = k < 4 ? k : k < 8 ? k + 4 : 16;
      if (b[p / 8] && w[p + 4]) f_upd[k] = w[p];
    end
  endfunction
  function automatic [31:0] f_pack(input [8:0] o);
    f_pack = {15'h0, o[8], 4'h0, o[7:4], 4'h0, o[3:0]};
  endfunction
  task test_done;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // back to back transfers keep psel high between them
  task automatic apb(input w, input [11:0] ad, input [31:0] wd, input [3:0] st, output [31:0] rd);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd; pstrb <= st;
    @(posedge mclk) penable <= 1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; test_done; end
    else rd = prdata;
  endtask
  initial begin
    void'($urandom(35739));
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    apb(0, 12'h00c, 0, 0, r); chk(r, 0);
    for (i = 0; i < 300; i++) begin
      d = i == 0 ? 32'h0011ffff : i == 1 ? 32'h0011f0f0 : $urandom & 32'h0011ffff;
      s = i < 4 ? 4'hf : 4'($urandom);
      a = i % 16 == 5 ? 12'h010 : 12'h00c;
      sel <= 9'($urandom); dir <= 9'($urandom);
      apb(1, a, d, s, r);
      if (a == 12'h00c) e = f_upd(e, d, s);
      apb(0, a, 0, 0, r); chk(r, a == 12'h00c ? f_pack(e) : 32'h0);
      chk(pin_out, e);
      chk(pin_oe_n, 9'(~(sel & ~dir)));
      chk(pslverr, 0);
      chk(pready, 1);
    end
    test_done;
  end
endmodule // testbench
